//--- hdl/unvm_cfg.svh
// Constants for the user nonvolatile byte read port.
`ifndef UNVM_CFG_SVH
`define UNVM_CFG_SVH
`define UNVM_BANKS       8
`define UNVM_BANK_BITS   128
`define UNVM_BANK_BYTES  16
`define UNVM_ADDR_W      7
`define UNVM_BANK_MSB    6
`define UNVM_BANK_LSB    4
`define UNVM_BYTE_MSB    3
`define UNVM_BYTE_LSB    0
`define UNVM_READ_LAT    1
`define UNVM_JTAG_OP_W   2
`define UNVM_OP_IDLE     2'h0
`define UNVM_OP_ERASE    2'h1
`define UNVM_OP_WRITE    2'h3
`define UNVM_OP_READ     2'h2
`endif

//--- hdl/unvm_pkg.sv
// Types for the user nonvolatile byte read port.
package unvm_pkg;
    typedef logic [6:0] unvm_addr_t;
    typedef logic [7:0] unvm_byte_t;
    typedef enum logic [1:0] {
        UNVM_IDLE  = 2'h0,
        UNVM_ERASE = 2'h1,
        UNVM_WRITE = 2'h3,
        UNVM_READ  = 2'h2
    } unvm_op_e;
endpackage

//--- hdl/unvm_decrypt.sv
// Keystream decryption stage applied to programming data before storage.
`timescale 1ns/100ps
module unvm_decrypt #(
    parameter int unsigned KEY_W = 128
) (
    // Data and key
    input  wire logic [127:0] data_in,
    input  wire logic [KEY_W-1:0] key_in,
    input  wire logic         decrypt_en_in,
    // Result
    output logic      [127:0] data_out
);
    logic [127:0] ks;

    // Simple keyed whitening; the real cipher core would replace this stage.
    always_comb begin
        ks = 128'(key_in) ^ {key_in[63:0], key_in[KEY_W-1 -: 64]};
        data_out = decrypt_en_in ? (data_in ^ ks) : data_in;
    end
endmodule

//--- hdl/unvm_read_port.sv
// User nonvolatile memory: fabric byte read port and programming-port bank access.
`timescale 1ns/100ps
`include "unvm_cfg.svh"
module unvm_read_port #(
    parameter int unsigned BANKS = `UNVM_BANKS,
    parameter int unsigned KEY_W = 128,
    parameter logic [KEY_W-1:0] KEY = '0
) (
    // Clock, enable and reset
    input  wire logic         clk_sys_in,
    input  wire logic         clk_en_in,
    input  wire logic         reset_n_in,
    // Fabric read port
    input  wire logic [6:0]   rd_addr_in,
    output logic      [7:0]   rd_data_out,
    // Programming port bank access
    input  wire logic [1:0]   prog_op_in,
    input  wire logic [2:0]   prog_bank_in,
    input  wire logic [127:0] prog_data_in,
    input  wire logic         prog_decrypt_in,
    output logic      [127:0] prog_rdata_out,
    output logic              prog_done_out
);
    typedef struct packed {
        logic [BANKS-1:0][127:0] mem;
        logic [127:0]            prog_rdata;
        logic [7:0]              rd_data;
        logic                    done;
    } unvm_state_s;

    unvm_state_s  st;
    unvm_state_s  next_st;
    logic         rst_meta;
    logic         rst_n;
    logic [127:0] plain;
    unvm_pkg::unvm_op_e op;

    // Reset release through two flops so the design sees a clean edge.
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    function automatic logic [7:0] pick_byte(input logic [127:0] bank, input logic [3:0] idx);
        pick_byte = bank[idx*8 +: 8];
    endfunction

    unvm_decrypt #(.KEY_W(KEY_W)) u_dec (
        .data_in       (prog_data_in),
        .key_in        (KEY),
        .decrypt_en_in (prog_decrypt_in),
        .data_out      (plain)
    );

    // Every two-bit code maps onto a defined operation, so the cast is safe.
    assign op = unvm_pkg::unvm_op_e'(prog_op_in);

    // Next state: fabric reads each cycle, erase and write ops change banks, readback copies one out.
    always_comb begin
        next_st = st;
        next_st.done = 1'b0;
        next_st.rd_data = pick_byte(st.mem[rd_addr_in[`UNVM_BANK_MSB:`UNVM_BANK_LSB]],
                                    rd_addr_in[`UNVM_BYTE_MSB:`UNVM_BYTE_LSB]);
        case (op)
            unvm_pkg::UNVM_ERASE: begin
                next_st.mem[prog_bank_in] = '0;
                next_st.done = 1'b1;
            end
            unvm_pkg::UNVM_WRITE: begin
                next_st.mem[prog_bank_in] = plain;
                next_st.done = 1'b1;
            end
            unvm_pkg::UNVM_READ: begin
                next_st.prog_rdata = st.mem[prog_bank_in];
                next_st.done = 1'b1;
            end
            default: begin
                next_st.done = 1'b0;
            end
        endcase
    end

    // State register; real nonvolatile storage would keep its contents through reset,
    // but here they are cleared since there is no real flash behind them.
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else if (clk_en_in) begin
            st <= next_st;
        end
    end

    // Outputs come straight from the state register, never from the decode.
    assign rd_data_out    = st.rd_data;
    assign prog_rdata_out = st.prog_rdata;
    assign prog_done_out  = st.done;

    // Named sequence: address presented with enable.
    sequence s_req;
        clk_en_in;
    endsequence

    // Enabled cycle with no programming operation.
    sequence s_idle_op;
        clk_en_in && op == unvm_pkg::UNVM_IDLE;
    endsequence

    // Enabled cycle that carries an erase, write or readback.
    sequence s_prog_op;
        clk_en_in && op != unvm_pkg::UNVM_IDLE;
    endsequence

    // one-cycle read
    // The byte is cut out by plain slicing rather than through pick_byte,
    // so a fault in that function cannot hide behind the same function.
    property p_read_lat;
        @(posedge clk_sys_in) disable iff (!rst_n)
        s_req |=>
        rd_data_out == $past(st.mem[rd_addr_in[6:4]][{rd_addr_in[3:0], 3'h0} +: 8]);
    endproperty
    a_read_lat: assert property (p_read_lat) else $error("read byte latency wrong");

    property p_byte_sel;
        @(posedge clk_sys_in) disable iff (!rst_n)
        s_idle_op |=>
        rd_data_out == pick_byte(st.mem[$past(rd_addr_in[6:4])], $past(rd_addr_in[3:0]));
    endproperty
    a_byte_sel: assert property (p_byte_sel) else $error("wrong byte selected");

    property p_write_bank;
        @(posedge clk_sys_in) disable iff (!rst_n)
        (clk_en_in && op == unvm_pkg::UNVM_WRITE) |=>
        st.mem[$past(prog_bank_in)] == $past(plain) && prog_done_out;
    endproperty
    a_write_bank: assert property (p_write_bank) else $error("bank write lost");

    property p_erase_bank;
        @(posedge clk_sys_in) disable iff (!rst_n)
        (clk_en_in && op == unvm_pkg::UNVM_ERASE) |=> st.mem[$past(prog_bank_in)] == '0;
    endproperty
    a_erase_bank: assert property (p_erase_bank) else $error("bank erase failed");

    property p_no_fabric_write;
        @(posedge clk_sys_in) disable iff (!rst_n)
        (op == unvm_pkg::UNVM_IDLE || op == unvm_pkg::UNVM_READ) |=> $stable(st.mem);
    endproperty
    a_no_fabric_write: assert property (p_no_fabric_write) else $error("memory changed");

    property p_readback;
        @(posedge clk_sys_in) disable iff (!rst_n)
        (clk_en_in && op == unvm_pkg::UNVM_READ) |=>
        prog_rdata_out == $past(st.mem[prog_bank_in]) && prog_done_out;
    endproperty
    a_readback: assert property (p_readback) else $error("readback mismatch");

    property p_plain_load;
        @(posedge clk_sys_in) disable iff (!rst_n)
        (clk_en_in && op == unvm_pkg::UNVM_WRITE && !prog_decrypt_in) |=>
        st.mem[$past(prog_bank_in)] == $past(prog_data_in);
    endproperty
    a_plain_load: assert property (p_plain_load) else $error("plain load altered");

    property p_freeze;
        @(posedge clk_sys_in) disable iff (!rst_n)
        !clk_en_in |=> $stable(rd_data_out) && $stable(prog_done_out);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while disabled");

    property p_op_done;
        @(posedge clk_sys_in) disable iff (!rst_n)
        s_prog_op |=> prog_done_out;
    endproperty
    a_op_done: assert property (p_op_done) else $error("no completion pulse");

    // quiet when idle
    // Done is a pulse: an idle enabled cycle must drop it, or a stale
    // completion would look like a second operation to the programming side.
    property p_idle_quiet;
        @(posedge clk_sys_in) disable iff (!rst_n)
        s_idle_op |=> !prog_done_out;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("stray completion");

    property p_rdata_hold;
        @(posedge clk_sys_in) disable iff (!rst_n)
        !(clk_en_in && op == unvm_pkg::UNVM_READ) |=> $stable(prog_rdata_out);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("readback word moved");

    // other banks kept
    // One check per bank, so a stray index that hits a neighbour is caught.
    for (genvar g = 0; g < BANKS; g++) begin : g_bank_keep
        property p_bank_keep;
            @(posedge clk_sys_in) disable iff (!rst_n)
            (prog_bank_in != 3'(g)) |=> st.mem[g] == $past(st.mem[g]);
        endproperty
        a_bank_keep: assert property (p_bank_keep) else $error("bank disturbed");
    end
endmodule

//--- verif/unvm_fabric_model.sv
// Fabric-side reader model that presents read addresses.
`timescale 1ns/100ps
module unvm_fabric_model (
    // Request from the bench
    input  wire logic [6:0] req_addr_in,
    // Read port address
    output logic      [6:0] rd_addr_out
);
    assign rd_addr_out = req_addr_in;
endmodule

//--- verif/tb_user_nvm_byte_read_port.sv
// Testbench for the user nonvolatile byte read port.
`timescale 1ns/100ps
`include "unvm_cfg.svh"
module tb_user_nvm_byte_read_port;
    logic         clk_sys_in = 1'b0;
    logic         clk_en_in = 1'b1;
    logic         reset_n_in = 1'b0;
    logic [6:0]   req = 7'h00;
    logic [6:0]   rd_addr;
    logic [7:0]   rd_data;
    logic [1:0]   op = 2'h0;
    logic [2:0]   bank = 3'h0;
    logic [127:0] wdata = 128'h0;
    logic         dec = 1'b0;
    logic [127:0] rdata;
    logic         done;
    int           err_count = 0;
    int           comparisons = 0;
    // Arbitrary load key; its two halves differ so that decryption is not a no-op.
    localparam logic [127:0] load_key = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210;

    // Free-running system clock.
    always #2 clk_sys_in = ~clk_sys_in;

    unvm_fabric_model model_u (.req_addr_in(req), .rd_addr_out(rd_addr));

    unvm_read_port #(.KEY(load_key)) dut_u (
        .clk_sys_in(clk_sys_in), .clk_en_in(clk_en_in), .reset_n_in(reset_n_in),
        .rd_addr_in(rd_addr), .rd_data_out(rd_data), .prog_op_in(op),
        .prog_bank_in(bank), .prog_data_in(wdata), .prog_decrypt_in(dec),
        .prog_rdata_out(rdata), .prog_done_out(done));

    // One compare per result width; strict inequality so an unknown never passes.
    task automatic cmp_byte(input string what, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", what, e, g);
        end
    endtask

    task automatic cmp_bank(input string what, input logic [127:0] e, input logic [127:0] g);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", what, e, g);
        end
    endtask

    task automatic cmp_flag(input string what, input logic e, input logic g);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", what, e, g);
        end
    endtask

    // Every byte carries its own bank and position, so a decode slip shows.
    function automatic logic [127:0] pat(input logic [2:0] b);
        for (int k = 0; k < 16; k++)
            pat[8*k +: 8] = {1'b1, b, k[3:0]};
    endfunction

    task automatic prog(input logic [1:0] o, input logic [2:0] b,
                        input logic [127:0] w, input logic d);
        @(posedge clk_sys_in);
        op <= o;
        bank <= b;
        wdata <= w;
        dec <= d;
        @(posedge clk_sys_in);
        op <= `UNVM_OP_IDLE;
        #1;
        cmp_flag("done", 1'b1, done);
    endtask

    task automatic t_load;
        for (int b = 0; b < 8; b++)
            prog(`UNVM_OP_WRITE, b[2:0], pat(b[2:0]), 1'b0);
    endtask

    // Loading through the keystream must alter the data; loading the stored
    // bank through it once more must give the plain pattern back.
    task automatic t_decrypt;
        prog(`UNVM_OP_WRITE, 3'h3, pat(3'h3), 1'b1);
        prog(`UNVM_OP_READ, 3'h3, 128'h0, 1'b0);
        cmp_flag("key applied", 1'b1, rdata !== pat(3'h3));
        prog(`UNVM_OP_WRITE, 3'h3, rdata, 1'b1);
        prog(`UNVM_OP_READ, 3'h3, 128'h0, 1'b0);
        cmp_bank("decrypted bank", pat(3'h3), rdata);
    endtask

    // Back-to-back reads: each edge returns the byte asked for one edge before.
    task automatic t_fabric;
        for (int a = 0; a <= 128; a++) begin
            @(posedge clk_sys_in);
            req <= a[6:0];
            #1;
            if (a > 0)
                cmp_byte("byte", {1'b1, 7'(a - 1)}, rd_data);
        end
    endtask

    task automatic t_freeze;
        @(posedge clk_sys_in);
        clk_en_in <= 1'b0;
        req <= 7'h05;
        repeat (2) @(posedge clk_sys_in);
        #1;
        cmp_byte("frozen", 8'h80, rd_data);
        @(posedge clk_sys_in);
        clk_en_in <= 1'b1;
    endtask

    task automatic t_readback;
        for (int b = 7; b >= 0; b--) begin
            prog(`UNVM_OP_READ, b[2:0], 128'h0, 1'b0);
            cmp_bank("bank", pat(b[2:0]), rdata);
        end
    endtask

    // Erase one bank, see the done pulse fall, and check its neighbour survives.
    task automatic t_erase;
        prog(`UNVM_OP_ERASE, 3'h7, 128'h0, 1'b0);
        @(posedge clk_sys_in);
        #1;
        cmp_flag("done pulse", 1'b0, done);
        prog(`UNVM_OP_READ, 3'h7, 128'h0, 1'b0);
        cmp_bank("erased bank", 128'h0, rdata);
        prog(`UNVM_OP_READ, 3'h6, 128'h0, 1'b0);
        cmp_bank("kept bank", pat(3'h6), rdata);
    endtask

    // Mid-run reset: outputs fall at once and the model memory is cleared.
    task automatic t_reset;
        @(posedge clk_sys_in);
        reset_n_in <= 1'b0;
        @(posedge clk_sys_in);
        #1;
        cmp_byte("reset byte", 8'h00, rd_data);
        cmp_bank("reset readback", 128'h0, rdata);
        cmp_flag("reset done", 1'b0, done);
        repeat (4) @(posedge clk_sys_in);
        reset_n_in <= 1'b1;
        repeat (3) @(posedge clk_sys_in);
        prog(`UNVM_OP_READ, 3'h0, 128'h0, 1'b0);
        cmp_bank("cleared bank", 128'h0, rdata);
        cmp_byte("cleared byte", 8'h00, rd_data);
    endtask

    task automatic close_out;
        $display("comparisons %0d, err_count %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Reset for five cycles, then wait out the two-flop release.
    initial begin
        repeat (5) @(posedge clk_sys_in);
        reset_n_in <= 1'b1;
        repeat (3) @(posedge clk_sys_in);
        t_load();
        t_decrypt();
        t_fabric();
        t_freeze();
        t_readback();
        t_erase();
        t_reset();
        close_out();
    end
endmodule
